/* File: rtl/rfs_avalon_slave.sv */
module rfs_avalon_slave (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic             waitrequest,
	output logic             wr_stb,
	output logic             rd_stb
);
	// one wait state per access: waitrequest idles high, drops for one cycle after a request is seen
	logic wait_q;
	logic next_wait;

	always_comb begin
		next_wait = ~((read | write) & wait_q);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			wait_q <= 1'b1;
		else
			wait_q <= next_wait;
	end

	assign waitrequest = wait_q;
	assign wr_stb      = write & ~wait_q;
	// readdata loads in the wait cycle so it already stands at the accepting edge
	assign rd_stb      = read & wait_q;
endmodule // rfs_avalon_slave

/* File: rtl/rfs_oc_counter.sv */
module rfs_oc_counter #(
	parameter int COUNT_LOW  = rfs_pkg::OC_COUNT_LOW,
	parameter int COUNT_HIGH = rfs_pkg::OC_COUNT_HIGH
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	rfs_oc_if.cnt     oc
);
	logic [rfs_pkg::OC_CNT_W-1:0] count;
	logic [rfs_pkg::OC_CNT_W-1:0] next_count;
	logic                         seen;
	logic                         next_seen;
	logic                         next_hiccup;
	logic [rfs_pkg::OC_CNT_W-1:0] limit;

	always_comb begin
		limit       = oc.out_low ? COUNT_LOW[rfs_pkg::OC_CNT_W-1:0] : COUNT_HIGH[rfs_pkg::OC_CNT_W-1:0];
		next_count  = count;
		next_seen   = seen | oc.oc_event;
		next_hiccup = 1'b0;
		if (!oc.enabled) begin
			next_count = '0;
			next_seen  = 1'b0;
		end else if (oc.oc_event) begin
			if (count + 7'h01 >= limit) begin
				next_hiccup = 1'b1;
				next_count  = '0;
			end else begin
				next_count = count + 7'h01;
			end
		end else if (oc.period_end) begin
			next_seen = 1'b0;
			if (!seen)
				next_count = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count     <= '0;
			seen      <= 1'b0;
			oc.hiccup <= 1'b0;
		end else begin
			count     <= next_count;
			seen      <= next_seen;
			oc.hiccup <= next_hiccup;
		end
	end
endmodule // rfs_oc_counter

/* File: rtl/rfs_oc_if.sv */
interface rfs_oc_if;
	logic enabled;
	logic period_end;
	logic oc_event;
	logic out_low;
	logic hiccup;

	modport sup (output enabled, output period_end, output oc_event, output out_low, input hiccup);
	modport cnt (input enabled, input period_end, input oc_event, input out_low, output hiccup);
endinterface

/* File: rtl/rfs_pkg.sv */
package rfs_pkg;

	// ----------------------------------------
	// register map (byte addresses, word aligned)
	// ----------------------------------------
	localparam logic [3:0]  ADDR_CTRL       = 4'h0;
	localparam logic [3:0]  ADDR_STATUS     = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0]  ADDR_IRQ_MASK   = 4'hc;

	// ----------------------------------------
	// control register fields and reset values
	// ----------------------------------------
	localparam int          CTRL_LOGIC_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
	localparam logic [7:0]  IRQ_MASK_RESET    = 8'h00;

	// ----------------------------------------
	// interrupt / event bit positions
	// ----------------------------------------
	localparam int EV_PREREG_HICCUP = 0;
	localparam int EV_BUCK_HICCUP   = 1;
	localparam int EV_LATCH         = 2;
	localparam int EV_CP_LOW        = 3;
	localparam int EV_PREREG_OV     = 4;
	localparam int EV_FSET          = 5;
	localparam int EV_FB_OPEN       = 6;
	localparam int EV_PGOOD_FALL    = 7;
	localparam int EV_W             = 8;

	// ----------------------------------------
	// fault counts
	// ----------------------------------------
	localparam int OC_COUNT_LOW   = 30;
	localparam int OC_COUNT_HIGH  = 120;
	localparam int OC_CNT_W       = 7;
	localparam int DIODE_MISS_CNT = 1;
	localparam int ILIM_CNT       = 2;

endpackage

/* File: rtl/rfs_supervisor.sv */
// Chosen here: register access over Avalon-MM and the register offsets.
module rfs_supervisor (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic             avs_waitrequest,
	output logic [31:0]      avs_readdata,
	output logic             irq,
	input  wire logic        ignition_enable_a,
	input  wire logic        ignition_enable_b,
	input  wire logic        logic_enable_input,
	input  wire logic        supply_ok,
	input  wire logic        prereg_period_end,
	input  wire logic        prereg_oc_event,
	input  wire logic        prereg_output_low,
	input  wire logic        prereg_ov,
	input  wire logic        prereg_output_open,
	input  wire logic        prereg_current_limit,
	input  wire logic        freewheel_diode_missing,
	input  wire logic        buck_period_end,
	input  wire logic        buck_oc_event,
	input  wire logic        buck_output_low,
	input  wire logic        buck_soft_start_low,
	input  wire logic        buck_high_side_limit,
	input  wire logic        buck_feedback_open,
	input  wire logic        buck_uv,
	input  wire logic        three_volt_uv,
	input  wire logic        five_volt_uv,
	input  wire logic        slew_pin_open_fault,
	input  wire logic        slew_pin_short_fault,
	input  wire logic        frequency_set_fault,
	input  wire logic        charge_pump_ov,
	input  wire logic        charge_pump_low_fault,
	output logic             master_reset_condition,
	output logic             master_latched,
	output logic             prereg_switch_enable,
	output logic             prereg_default_freq,
	output logic             prereg_max_duty,
	output logic             boost_enable,
	output logic             prereg_hiccup,
	output logic             buck_enable,
	output logic             buck_switch_node_off,
	output logic             buck_error_amp_low,
	output logic             buck_hiccup,
	output logic             ldo_enable,
	output logic             power_good_reset_n,
	output logic             five_volt_good_flag
);
	// ----------------------------------------
	// bus slave and registers
	// ----------------------------------------
	logic                     wr_stb;
	logic                     rd_stb;
	logic [31:0]              ctrl;
	logic [31:0]              next_ctrl;
	logic [rfs_pkg::EV_W-1:0] irq_status;
	logic [rfs_pkg::EV_W-1:0] next_irq_status;
	logic [rfs_pkg::EV_W-1:0] irq_mask;
	logic [rfs_pkg::EV_W-1:0] next_irq_mask;
	logic [31:0]              next_readdata;
	logic [rfs_pkg::EV_W-1:0] events;

	rfs_avalon_slave u_bus (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.address     (avs_address),
		.read        (avs_read),
		.write       (avs_write),
		.writedata   (avs_writedata),
		.byteenable  (avs_byteenable),
		.waitrequest (avs_waitrequest),
		.wr_stb      (wr_stb),
		.rd_stb      (rd_stb)
	);

	// ----------------------------------------
	// overcurrent counters
	// ----------------------------------------
	rfs_oc_if prereg_oc ();
	rfs_oc_if buck_oc ();
	logic     enable;
	logic     active;

	always_comb begin
		enable = ignition_enable_a | ignition_enable_b | logic_enable_input
			| ctrl[rfs_pkg::CTRL_LOGIC_EN_BIT];
	end

	assign prereg_oc.enabled    = active;
	assign prereg_oc.period_end = prereg_period_end;
	assign prereg_oc.oc_event   = prereg_oc_event;
	assign prereg_oc.out_low    = prereg_output_low;
	// soft-start below hiccup level: events are not counted, pulse limit only
	assign buck_oc.enabled      = active & ~buck_soft_start_low & ~frequency_set_fault;
	assign buck_oc.period_end   = buck_period_end;
	assign buck_oc.oc_event     = buck_oc_event;
	assign buck_oc.out_low      = buck_output_low;

	rfs_oc_counter u_prereg_oc (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.oc      (prereg_oc)
	);

	rfs_oc_counter u_buck_oc (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.oc      (buck_oc)
	);

	// ----------------------------------------
	// latched faults
	// ----------------------------------------
	logic       latch;
	logic       next_latch;
	logic [1:0] ilim_cnt;
	logic [1:0] next_ilim_cnt;
	logic       enable_q;
	logic       supply_q;
	logic       cycle_clear;
	logic       nonlatched_mr;

	always_comb begin
		// a falling enable or supply clears the latch; a new slew-pin or pump overvoltage fault still wins
		cycle_clear   = (enable_q & ~enable) | (supply_q & ~supply_ok);
		nonlatched_mr = charge_pump_low_fault | ~supply_ok;
		next_ilim_cnt = ilim_cnt;
		next_latch    = latch;
		if (cycle_clear) begin
			next_latch    = 1'b0;
			next_ilim_cnt = 2'h0;
		end
		if (active && prereg_current_limit && ilim_cnt < 2'(rfs_pkg::ILIM_CNT))
			next_ilim_cnt = ilim_cnt + 2'h1;
		if (active && prereg_current_limit && ilim_cnt == 2'(rfs_pkg::ILIM_CNT - 1))
			next_latch = 1'b1;
		if (active && freewheel_diode_missing)
			next_latch = 1'b1;
		if (slew_pin_open_fault | slew_pin_short_fault)
			next_latch = 1'b1;
		if (charge_pump_ov)
			next_latch = 1'b1;
	end

	always_comb begin
		active = enable & ~latch & ~nonlatched_mr;
	end

	// ----------------------------------------
	// regulator control and status outputs
	// ----------------------------------------
	logic mr;
	logic pg_ok;
	logic fv_ok;

	always_comb begin
		mr    = latch | nonlatched_mr;
		// open feedback reads as buck undervoltage; 5 V flag ignores it
		pg_ok = active & ~frequency_set_fault & ~buck_uv & ~buck_feedback_open
			& ~three_volt_uv & ~five_volt_uv & ~prereg_oc.hiccup & ~buck_oc.hiccup;
		fv_ok = active & ~frequency_set_fault & ~five_volt_uv & ~prereg_oc.hiccup;
		events = '0;
		events[rfs_pkg::EV_PREREG_HICCUP] = prereg_oc.hiccup;
		events[rfs_pkg::EV_BUCK_HICCUP]   = buck_oc.hiccup;
		events[rfs_pkg::EV_LATCH]         = next_latch & ~latch;
		events[rfs_pkg::EV_CP_LOW]        = charge_pump_low_fault;
		events[rfs_pkg::EV_PREREG_OV]     = prereg_ov;
		events[rfs_pkg::EV_FSET]          = frequency_set_fault;
		events[rfs_pkg::EV_FB_OPEN]       = buck_feedback_open;
		events[rfs_pkg::EV_PGOOD_FALL]    = power_good_reset_n & ~pg_ok;
	end

	// ----------------------------------------
	// register access
	// ----------------------------------------
	always_comb begin
		next_ctrl       = ctrl;
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		next_readdata   = avs_readdata;
		if (wr_stb && avs_byteenable[0]) begin
			case (avs_address)
				rfs_pkg::ADDR_CTRL:       next_ctrl[7:0]  = avs_writedata[7:0];
				rfs_pkg::ADDR_IRQ_MASK:   next_irq_mask   = avs_writedata[rfs_pkg::EV_W-1:0];
				rfs_pkg::ADDR_IRQ_STATUS: next_irq_status = irq_status & ~avs_writedata[rfs_pkg::EV_W-1:0];
				default:                  next_ctrl       = ctrl;
			endcase
		end
		next_irq_status = next_irq_status | events; // set beats clear
		if (rd_stb) begin
			case (avs_address)
				rfs_pkg::ADDR_CTRL:       next_readdata = ctrl;
				rfs_pkg::ADDR_STATUS:     next_readdata = {24'h0, power_good_reset_n, five_volt_good_flag,
					buck_hiccup, prereg_hiccup, enable, nonlatched_mr, latch, mr};
				rfs_pkg::ADDR_IRQ_STATUS: next_readdata = {24'h0, irq_status};
				rfs_pkg::ADDR_IRQ_MASK:   next_readdata = {24'h0, irq_mask};
				default:                  next_readdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	logic next_prereg_switch_enable;
	logic next_prereg_default_freq;
	logic next_prereg_max_duty;
	logic next_boost_enable;
	logic next_prereg_hiccup;
	logic next_buck_enable;
	logic next_buck_switch_node_off;
	logic next_buck_error_amp_low;
	logic next_buck_hiccup;
	logic next_ldo_enable;
	logic next_irq;

	always_comb begin
		// overvoltage only pauses switching; nothing here feeds the latch
		next_prereg_switch_enable = active & ~prereg_ov & ~prereg_oc.hiccup;
		// pin fault: default frequency on; boost and everything downstream stay off
		next_prereg_default_freq  = active & frequency_set_fault;
		next_prereg_max_duty      = active & prereg_output_open;
		next_boost_enable         = active & ~frequency_set_fault;
		next_prereg_hiccup        = prereg_oc.hiccup;
		next_buck_enable          = active & ~frequency_set_fault & ~buck_oc.hiccup;
		// pulse limit only; the power stage keeps its period running
		next_buck_switch_node_off = buck_soft_start_low & buck_high_side_limit;
		next_buck_error_amp_low   = buck_feedback_open;
		next_buck_hiccup          = buck_oc.hiccup;
		next_ldo_enable           = active & ~frequency_set_fault;
		next_irq                  = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl                   <= rfs_pkg::CTRL_RESET;
			irq_status             <= '0;
			irq_mask               <= rfs_pkg::IRQ_MASK_RESET;
			avs_readdata           <= 32'h0;
			irq                    <= 1'b0;
			latch                  <= 1'b0;
			ilim_cnt               <= 2'h0;
			enable_q               <= 1'b0;
			supply_q               <= 1'b0;
			master_reset_condition <= 1'b1;
			master_latched         <= 1'b0;
			prereg_switch_enable   <= 1'b0;
			prereg_default_freq    <= 1'b0;
			prereg_max_duty        <= 1'b0;
			boost_enable           <= 1'b0;
			prereg_hiccup          <= 1'b0;
			buck_enable            <= 1'b0;
			buck_switch_node_off   <= 1'b0;
			buck_error_amp_low     <= 1'b0;
			buck_hiccup            <= 1'b0;
			ldo_enable             <= 1'b0;
			power_good_reset_n     <= 1'b0;
			five_volt_good_flag    <= 1'b0;
		end else begin
			ctrl                   <= next_ctrl;
			irq_status             <= next_irq_status;
			irq_mask               <= next_irq_mask;
			avs_readdata           <= next_readdata;
			irq                    <= next_irq;
			latch                  <= next_latch;
			ilim_cnt               <= next_ilim_cnt;
			enable_q               <= enable;
			supply_q               <= supply_ok;
			master_reset_condition <= mr;
			master_latched         <= latch;
			prereg_switch_enable   <= next_prereg_switch_enable;
			prereg_default_freq    <= next_prereg_default_freq;
			prereg_max_duty        <= next_prereg_max_duty;
			boost_enable           <= next_boost_enable;
			prereg_hiccup          <= next_prereg_hiccup;
			buck_enable            <= next_buck_enable;
			buck_switch_node_off   <= next_buck_switch_node_off;
			buck_error_amp_low     <= next_buck_error_amp_low;
			buck_hiccup            <= next_buck_hiccup;
			ldo_enable             <= next_ldo_enable;
			power_good_reset_n     <= pg_ok;
			five_volt_good_flag    <= fv_ok;
		end
	end
endmodule // rfs_supervisor

/* File: test/rfs_stage_model.sv */
module rfs_stage_model #(
	parameter int PERIOD = 4
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic running,
	input  wire logic short_en,
	output logic      period_end,
	output logic      oc_event
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ph;
	logic [7:0] next_ph;

	// ----------------------------------------
	// switching period phase
	// ----------------------------------------
	always_comb begin
		next_ph = (!running || ph == 8'(PERIOD - 1)) ? 8'h00 : ph + 8'h01;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ph <= 8'h00;
		end else begin
			ph <= next_ph;
		end
	end

	// one trip per shorted period, kept off the closing cycle
	assign period_end = running && ph == 8'(PERIOD - 1);
	assign oc_event   = running && short_en && ph == 8'(PERIOD - 2);
endmodule // rfs_stage_model

/* File: test/rfs_supervisor_properties.sv */
module rfs_sup_props (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic freewheel_diode_missing,
	input wire logic prereg_current_limit,
	input wire logic slew_pin_open_fault,
	input wire logic slew_pin_short_fault,
	input wire logic charge_pump_ov,
	input wire logic charge_pump_low_fault,
	input wire logic ignition_enable_a,
	input wire logic ignition_enable_b,
	input wire logic logic_enable_input,
	input wire logic supply_ok,
	input wire logic prereg_ov,
	input wire logic frequency_set_fault,
	input wire logic prereg_oc_event,
	input wire logic buck_soft_start_low,
	input wire logic master_reset_condition,
	input wire logic master_latched,
	input wire logic prereg_switch_enable,
	input wire logic prereg_hiccup,
	input wire logic buck_enable,
	input wire logic buck_hiccup,
	input wire logic ldo_enable,
	input wire logic power_good_reset_n,
	input wire logic five_volt_good_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// fault responses
	// ----------------------------------------
	// latch sets one edge after the fault, the latch outputs one edge later
	AST_DIODE_LATCH: assert property (freewheel_diode_missing |-> ##2 master_latched)
		else $error("diode fault not latched");
	AST_ILIM_SECOND: assert property (prereg_current_limit ##[1:8] prereg_current_limit |-> ##2 master_latched)
		else $error("second limit hit not latched");
	AST_SLEW_LATCH: assert property ((slew_pin_open_fault || slew_pin_short_fault)
		|-> ##2 master_latched && master_reset_condition)
		else $error("slew fault not latched");
	AST_CP_OV_LATCH: assert property (charge_pump_ov |-> ##2 master_latched)
		else $error("pump overvoltage not latched");
	AST_LATCH_STATUS: assert property (master_latched
		|=> !power_good_reset_n && !five_volt_good_flag && !ldo_enable)
		else $error("status high while latched");
	AST_CP_LOW_RESET: assert property (charge_pump_low_fault |=> master_reset_condition)
		else $error("pump low without reset");
	// only a falling combined enable or supply may clear the latch
	AST_LATCH_HOLD: assert property (master_latched && supply_ok
		&& (ignition_enable_a || ignition_enable_b || logic_enable_input) |=> master_latched)
		else $error("latch lost while enabled");
	AST_OV_PAUSE: assert property (prereg_ov |=> !prereg_switch_enable)
		else $error("switching during overvoltage");
	AST_FSET_OFF: assert property (frequency_set_fault |=> !buck_enable && !ldo_enable)
		else $error("regulators on with pin fault");
	AST_HICCUP_CAUSE: assert property ($rose(prereg_hiccup) |-> $past(prereg_oc_event, 2))
		else $error("hiccup without event");
	AST_SOFT_NO_HIC: assert property (buck_soft_start_low |=> !buck_hiccup)
		else $error("buck hiccup in soft start");
endmodule // rfs_sup_props

bind rfs_supervisor rfs_sup_props chk_u (.*);

/* File: test/rfs_supervisor_tb.sv */
module rfs_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, irq;
	logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        ignition_enable_a = 1'h0, ignition_enable_b = 1'h0, logic_enable_input = 1'h1, supply_ok = 1'h1;
	logic        prereg_output_low = 1'h0, prereg_ov = 1'h0, prereg_output_open = 1'h0, prereg_current_limit = 1'h0;
	logic        freewheel_diode_missing = 1'h0, buck_output_low = 1'h0, buck_soft_start_low = 1'h0, buck_uv = 1'h0;
	logic        buck_high_side_limit = 1'h0, buck_feedback_open = 1'h0, three_volt_uv = 1'h0, five_volt_uv = 1'h0;
	logic        slew_pin_open_fault = 1'h0, slew_pin_short_fault = 1'h0, frequency_set_fault = 1'h0;
	logic        charge_pump_ov = 1'h0, charge_pump_low_fault = 1'h0, p_short = 1'h0, b_short = 1'h0;
	logic        prereg_period_end, prereg_oc_event, buck_period_end, buck_oc_event, master_reset_condition;
	logic        master_latched, prereg_switch_enable, prereg_default_freq, prereg_max_duty, boost_enable;
	logic        prereg_hiccup, buck_enable, buck_switch_node_off, buck_error_amp_low, buck_hiccup, ldo_enable;
	logic        power_good_reset_n, five_volt_good_flag;
	int          n_errors = 0, tests_run = 0, p_n = 0, p_hic = 0, b_n = 0, b_hic = 0;
	// mask and expected pattern of obs() while each non-latched fault is held
	localparam logic [7:0] MK [5:12] = '{8'h20, 8'h1e, 8'h07, 8'h06, 8'h46, 8'h80, 8'h06, 8'h06};
	localparam logic [7:0] EV [5:12] = '{8'h20, 8'h10, 8'h03, 8'h02, 8'h06, 8'h80, 8'h00, 8'h02};

	rfs_supervisor dut_u (.*);
	rfs_stage_model pre_u (.clk_sys(clk_sys), .rstn(rstn), .running(prereg_switch_enable), .short_en(p_short),
		.period_end(prereg_period_end), .oc_event(prereg_oc_event));
	rfs_stage_model buck_u (.clk_sys(clk_sys), .rstn(rstn), .running(buck_enable), .short_en(b_short),
		.period_end(buck_period_end), .oc_event(buck_oc_event));

	always #20 clk_sys = ~clk_sys;

	// sampled mid-cycle so counts never race the registered outputs
	always @(negedge clk_sys) begin
		if (prereg_oc_event === 1'h1) p_n++;
		if (prereg_hiccup === 1'h1 && p_hic == 0) p_hic = p_n;
		if (buck_oc_event === 1'h1) b_n++;
		if (buck_hiccup === 1'h1) b_hic++;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] obs();
		return {prereg_max_duty, prereg_switch_enable, master_reset_condition, prereg_default_freq,
			ldo_enable | buck_enable | boost_enable, power_good_reset_n, five_volt_good_flag, buck_error_amp_low};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic w;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(negedge clk_sys);
			w = avs_waitrequest;
			// read data as it stands at the accepting edge
			q = avs_readdata;
			@(posedge clk_sys);
		end while (w !== 1'h0);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(negedge clk_sys);
	endtask

	task automatic setf(input int k, input logic v);
		case (k)
			0: freewheel_diode_missing <= v;
			1: prereg_current_limit <= v;
			2: slew_pin_open_fault <= v;
			3: slew_pin_short_fault <= v;
			4: charge_pump_ov <= v;
			5: charge_pump_low_fault <= v;
			6: frequency_set_fault <= v;
			7: buck_feedback_open <= v;
			8: three_volt_uv <= v;
			9: prereg_ov <= v;
			10: prereg_output_open <= v;
			11: five_volt_uv <= v;
			default: buck_uv <= v;
		endcase
	endtask

	task automatic pulse(input int k);
		@(posedge clk_sys);
		setf(k, 1'h1);
		@(posedge clk_sys);
		setf(k, 1'h0);
		cyc(3);
	endtask

	task automatic hic(input logic lowv, input int n, input int exp);
		@(posedge clk_sys);
		prereg_output_low <= lowv;
		p_short <= 1'h1;
		p_n = 0;
		p_hic = 0;
		while (p_n < n) @(posedge clk_sys);
		p_short <= 1'h0;
		cyc(12);
		chk(p_hic, exp);
	endtask

	task automatic final_report();
		$display("errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		bus(1'h0, rfs_pkg::ADDR_IRQ_MASK, 32'h0);
		chk(q, 32'h0);
		bus(1'h1, rfs_pkg::ADDR_CTRL, 32'h1);
		bus(1'h0, rfs_pkg::ADDR_CTRL, 32'h0);
		chk(q, 32'h1);
		bus(1'h1, rfs_pkg::ADDR_CTRL, 32'h0);
		bus(1'h0, 4'h2, 32'h0);
		chk(q, 32'h0);
		cyc(20);
		hic(1'h1, 30, 30);
		chk(irq, 1'h0);
		bus(1'h0, rfs_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(q & 32'h1, 32'h1);
		bus(1'h1, rfs_pkg::ADDR_IRQ_MASK, 32'h1);
		cyc(2);
		chk(irq, 1'h1);
		bus(1'h1, rfs_pkg::ADDR_IRQ_STATUS, 32'hff);
		cyc(2);
		chk(irq, 1'h0);
		hic(1'h1, 29, 0);
		hic(1'h1, 30, 30);
		hic(1'h0, 120, 120);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			ignition_enable_a <= (i % 4 == 0);
			ignition_enable_b <= (i % 4 == 1);
			logic_enable_input <= (i % 4 >= 2);
			cyc(4);
			pulse(i);
			if (i == 1) begin
				chk(master_latched, 1'h0);
				pulse(i);
			end
			chk(master_latched, 1'h1);
			chk(obs() & 8'h2e, 8'h20);
			@(posedge clk_sys);
			case (i % 4)
				0: ignition_enable_a <= 1'h0;
				1: ignition_enable_b <= 1'h0;
				2: logic_enable_input <= 1'h0;
				default: supply_ok <= 1'h0;
			endcase
			cyc(3);
			chk(master_latched, 1'h0);
			@(posedge clk_sys);
			ignition_enable_a <= 1'h0;
			ignition_enable_b <= 1'h0;
			logic_enable_input <= 1'h1;
			supply_ok <= 1'h1;
		end
		for (int k = 5; k < 13; k++) begin
			@(posedge clk_sys);
			setf(k, 1'h1);
			cyc(4);
			chk(obs() & MK[k], EV[k]);
			chk(master_latched, 1'h0);
			@(posedge clk_sys);
			setf(k, 1'h0);
			cyc(8);
			chk(obs() & (k == 9 ? 8'h60 : 8'h20), (k == 9 ? 8'h40 : 8'h00));
		end
		@(posedge clk_sys);
		buck_output_low <= 1'h1;
		b_short <= 1'h1;
		b_n = 0;
		b_hic = 0;
		while (b_n < 30) @(posedge clk_sys);
		b_short <= 1'h0;
		cyc(12);
		chk(b_hic, 1);
		@(posedge clk_sys);
		buck_soft_start_low <= 1'h1;
		buck_output_low <= 1'h1;
		buck_high_side_limit <= 1'h1;
		b_short <= 1'h1;
		b_n = 0;
		b_hic = 0;
		while (b_n < 130) @(posedge clk_sys);
		cyc(1);
		chk(buck_switch_node_off, 1'h1);
		chk(b_hic, 0);
		final_report();
	end

	// whole sequence is near 1800 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		final_report();
	end
endmodule // rfs_supervisor_tb
